// ---- dv/oc_ot_config_tb_top.sv ----
// Testbench for the overcurrent and overtemperature configuration block
`timescale 1ns/10ps
module oc_ot_config_tb_top import oc_ot_pkg::*; ;
  localparam int RW = 20;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic valid, busy, done, on, ok, nvm, clr, trip, pwr, ot, alert_n;
  txn_t txn;
  logic [15:0] rd;
  logic [7:0] sel;
  logic [1:0][10:0] iout;
  logic signed [15:0] temp, owarn;
  logic [1:0] warn;
  status_t st;
  logic [16:0] exq[$];
  logic [16:0] note;
  int err_count = 0;
  int check_count = 0;
  // ==========================================================
  // Clocks: link clock free-running, phase offset from core clock
  initial forever #5 clock = ~clock;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  oc_ot_config #(.NUM_PHASES(2), .RESTART_WAIT(RW)) dut (
    .clock_i(clock), .reset_n_i(reset_n), .link_clk_i(link_clk),
    .txn_valid_i(valid), .txn_i(txn), .txn_busy_o(busy), .txn_done_o(done),
    .rd_data_o(rd), .phase_sel_i(sel), .oc_trip_i(trip), .iout_meas_i(iout),
    .temp_meas_i(temp), .ot_warn_limit_i(owarn), .commanded_on_i(on),
    .startup_ok_i(ok), .nvm_restore_i(nvm), .clear_faults_i(clr),
    .power_enable_o(pwr), .phase_warn_o(warn), .ot_fault_o(ot),
    .status_o(st), .alert_n_o(alert_n));
  oc_ot_host host (.link_clk_i(link_clk), .done_i(done), .valid_o(valid),
    .txn_o(txn));
  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    exq.push_back(17'h00000);
    host.xfer({1'b1, c != CMD_OC_REACTION, c, d});
    cyc(6);
  endtask : wr
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    exq.push_back({1'b1, e});
    host.xfer({1'b0, c != CMD_OC_REACTION, c, 16'h0000});
  endtask : rdc
  task automatic clear;
    @(posedge clock) clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
    cyc(3);
  endtask : clear
  task automatic trip_for(input int n);
    @(posedge clock) trip <= 1'b1;
    cyc(n);
    trip <= 1'b0;
    cyc(12);
  endtask : trip_for
  task automatic tchk(input logic [15:0] t, input logic e);
    @(posedge clock) temp <= t;
    cyc(6);
    check(ot, e);
  endtask : tchk
  task automatic stop_test;
    err_count += host.timeout_count;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Read results matched in order against the oldest note
  always @(negedge link_clk) begin
    if (done === 1'b1 && exq.size() > 0) begin
      note = exq.pop_front();
      check(busy, 1'b0);
      if (note[16]) check(rd, note[15:0]);
    end
  end
  // Watchdog sized well above the whole sequence
  initial begin
    #900us;
    err_count++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] b;
    logic [10:0] lim [3];
    logic [10:0] thr [3];
    lim = '{11'd9, 11'd3, 11'd62};
    thr = '{11'd80, 11'd64, 11'd496};
    sel = 8'h00;
    trip = 1'b0;
    iout = '0;
    temp = 16'h0000;
    owarn = 16'h05A0;
    on = 1'b1;
    ok = 1'b0;
    nvm = 1'b0;
    clr = 1'b0;
    b = 8'($urandom(32'h0252));
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge link_clk);
    rdc(CMD_OC_REACTION, 16'h00BA);
    rdc(CMD_OT_FAULT, 16'h007D);
    rdc(CMD_OC_WARN, 16'hE990);
    // Immediate shutdown, no restart; delay bits random and ignored
    b = {5'b11000, 3'($urandom())};
    wr(CMD_OC_REACTION, {8'h00, b});
    rdc(CMD_OC_REACTION, {8'h00, b[7:3], 3'b010});
    clear();
    trip_for(3 * RW);
    check({st.byte_oc, st.iout_ocf, st.word_iout, alert_n}, 4'hE);
    check(pwr, 1'b0);
    @(posedge clock) on <= 1'b0;
    cyc(4);
    on <= 1'b1;
    ok <= 1'b1;
    cyc(8);
    ok <= 1'b0;
    check(pwr, 1'b1);
    // Ignore codes keep running
    for (int i = 0; i < 2; i++) begin
      wr(CMD_OC_REACTION, {8'h00, 2'(i), 6'h00});
      trip_for(20);
      check(pwr, 1'b1);
    end
    // Delayed shutdown: short trip rides through, long one stops
    wr(CMD_OC_REACTION, 16'h00B8);
    trip_for(3);
    check(pwr, 1'b1);
    @(posedge clock) trip <= 1'b1;
    cyc(16);
    check(pwr, 1'b0);
    cyc(10 * RW); // More attempts than any finite count allows
    trip <= 1'b0;
    cyc(3 * RW);
    ok <= 1'b1;
    cyc(8);
    ok <= 1'b0;
    check(pwr, 1'b1);
    // One restart attempt, then latched despite the trip clearing
    wr(CMD_OC_REACTION, 16'h00C8);
    trip_for(4 * RW);
    cyc(3 * RW);
    check(pwr, 1'b0);
    // Warning thresholds: step rounding, clamp, top value, phase 1 quiet
    for (int i = 0; i < 3; i++) begin
      wr(CMD_OC_WARN, {5'h00, lim[i]});
      clear();
      @(posedge clock) iout[0] <= thr[i] - 11'($urandom_range(0, 7));
      cyc(6);
      check(warn, 2'b00);
      iout[0] <= thr[i] + 11'd1;
      cyc(6);
      check(warn, 2'b01);
      check({st.iout_ocw, st.byte_nota, st.word_iout}, 3'h7);
      iout[0] <= 11'd0;
    end
    // Over-range and wrong-size writes refused and flagged
    clear();
    wr(CMD_OC_WARN, 16'h003F);
    check({st.cml_data, alert_n}, 2'b10);
    clear();
    exq.push_back(17'h00000);
    host.xfer({1'b1, 1'b1, CMD_OC_REACTION, 16'h0000});
    cyc(6);
    check(st.cml_data, 1'b1);
    // Unknown command reads back zero and is flagged
    clear();
    rdc(8'h48, 16'h0000);
    cyc(6);
    check(st.cml_data, 1'b1);
    // All-phase write splits the value; single selector touches one
    sel <= 8'hFF;
    wr(CMD_OC_WARN, 16'h0028);
    rdc(CMD_OC_WARN, 16'hF850);
    sel <= 8'h01;
    wr(CMD_OC_WARN, 16'h001E);
    rdc(CMD_OC_WARN, 16'hE8F0);
    sel <= 8'h00;
    rdc(CMD_OC_WARN, 16'hE8A0);
    // Restore rounds 10.125 A to the 0.25 A grid
    wr(CMD_OC_WARN, 16'hE851);
    @(posedge clock) nvm <= 1'b1;
    @(posedge clock) nvm <= 1'b0;
    rdc(CMD_OC_WARN, 16'hE852);
    // Overtemperature at 100.5 degC, release and hysteresis, disable
    wr(CMD_OT_FAULT, 16'hF8C9);
    tchk(16'h0644, 1'b0);
    tchk(16'h064C, 1'b1);
    tchk(16'h05DC, 1'b1);
    tchk(16'h0596, 1'b0);
    @(posedge clock) owarn <= 16'h0780;
    tchk(16'h064C, 1'b1);
    tchk(16'h0514, 1'b1);
    tchk(16'h0500, 1'b0);
    // Restore brings 100.5 degC back as the nearest whole degree
    @(posedge clock) nvm <= 1'b1;
    @(posedge clock) nvm <= 1'b0;
    rdc(CMD_OT_FAULT, 16'h0065);
    wr(CMD_OT_FAULT, 16'h00FF);
    tchk(16'h12C0, 1'b0);
    stop_test();
  end
endmodule : oc_ot_config_tb_top

// ---- dv/oc_ot_host.sv ----
// Host model issuing one link transfer at a time
`timescale 1ns/10ps
module oc_ot_host import oc_ot_pkg::*; (
  input wire logic link_clk_i,
  input wire logic done_i,
  output logic valid_o,
  output txn_t txn_o
);
  // ==========================================================
  // Idle bus shows the inverse of the last request, never stale data
  initial begin
    valid_o = 1'b0;
    txn_o = '0;
  end
  // Transfers that never saw done; the bench counts them as mismatches
  int timeout_count = 0;
  // One-cycle request, then wait for done under a bound
  task automatic xfer(input txn_t t);
    int n;
    n = 0;
    @(posedge link_clk_i);
    valid_o <= 1'b1;
    txn_o <= t;
    @(posedge link_clk_i);
    valid_o <= 1'b0;
    txn_o <= ~t;
    #1;
    while (done_i !== 1'b1 && n < 20) begin
      @(posedge link_clk_i);
      #1;
      n++;
    end
    if (done_i !== 1'b1) timeout_count++;
  endtask : xfer
endmodule : oc_ot_host

// ---- hdl/oc_ot_config.sv ----
// Overcurrent and overtemperature limit, reaction and status logic
//
// Contract
// - Overcurrent fault sets byte, word, current status bits; alerts host
// - Reaction code: 00/01 ignore, 10 delayed shutdown, 11 immediate
// - Restart count zero latches off after overcurrent shutdown
// - Counts one to six: wait restart period, retry that often, latch
// - Count seven retries forever until commanded off or start-up succeeds
// - Unsupported written values are refused, flagged, host alerted
// - Reaction command is a byte at 47h, effective at once
// - Each phase compares its own warning limit independently
// - Warning sets none-of-above, word and current bits, alerts host
// - Warning limits accepted up to 62 A, or 62 A times phase count with selector FFh
// - Applied per-phase limit in 2 A steps, 8 to 62 A, rounded up
// - Limits below 8 A accepted but applied as 8 A
// - Restore rounds current limits to nearest 0.25 A, max 62 A
// - Limit word: exponent 15:11 resetting to zero, mantissa 10:0
// - Full resolution compare; restore gives whole degrees 0 to 160
// - Limit 255 degC disables programmable overtemperature fault
// - Fault clears below warning limit, else 20 degC under fault limit
// - Selector FFh writes value divided by phases; else one phase
`timescale 1ns/10ps
module oc_ot_config import oc_ot_pkg::*; #(
  parameter int NUM_PHASES = 1,
  parameter int RESTART_WAIT = RESTART_WAIT_CYC,
  parameter logic [7:0] RESP_DEFAULT = 8'hBA,
  parameter logic [9:0] WARN_DEFAULT = 10'h190,
  parameter logic [10:0] OT_DEFAULT_DEG = 11'h07D
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic txn_valid_i,
  input wire txn_t txn_i,
  output logic txn_busy_o,
  output logic txn_done_o,
  output logic [15:0] rd_data_o,
  input wire logic [7:0] phase_sel_i,
  input wire logic oc_trip_i,
  input wire logic [NUM_PHASES-1:0][10:0] iout_meas_i,
  input wire logic signed [15:0] temp_meas_i,
  input wire logic signed [15:0] ot_warn_limit_i,
  input wire logic commanded_on_i,
  input wire logic startup_ok_i,
  input wire logic nvm_restore_i,
  input wire logic clear_faults_i,
  output logic power_enable_o,
  output logic [NUM_PHASES-1:0] phase_warn_o,
  output logic ot_fault_o,
  output status_t status_o,
  output logic alert_n_o
);
  if (NUM_PHASES < 1 || NUM_PHASES > 4) begin : g_bad_phases
    $error("NUM_PHASES must be 1 to 4");
  end
  if (RESTART_WAIT < 2) begin : g_bad_wait
    $error("RESTART_WAIT must be at least 2");
  end

  // Linear word to fixed point, rounding up any dropped fraction
  function automatic logic signed [31:0] lin_val(
    input signed_linear_word_format_t w, input int frac);
    int sh;
    logic signed [31:0] m;
    m = 32'(signed'(w.mantissa));
    sh = int'(signed'(w.exponent)) + frac;
    if (sh >= 0) begin
      lin_val = m <<< sh;
    end else begin
      lin_val = (m + (32'sd1 <<< -sh) - 32'sd1) >>> -sh;
    end
  endfunction : lin_val

  // ==========================================================
  // Link domain: hold request, toggle across, wait for ack
  txn_t lreq_q;
  logic req_tgl_q, busy_q, done_q;
  logic ack_s1_q, ack_s2_q, ack_seen_q;
  logic [15:0] rd_q, rd_word_q;
  logic ack_tgl_q;
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
    end
  end
  // New requests refused while one is in flight
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lreq_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_seen_q <= 1'b0;
      rd_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (txn_valid_i && !busy_q) begin
        lreq_q <= txn_i;
        req_tgl_q <= ~req_tgl_q;
        busy_q <= 1'b1;
      end else if (ack_s2_q != ack_seen_q) begin
        ack_seen_q <= ack_s2_q;
        busy_q <= 1'b0;
        done_q <= 1'b1;
        rd_q <= rd_word_q; // Held stable until the next transfer completes
      end
    end
  end
  assign txn_busy_o = busy_q;
  assign txn_done_o = done_q;
  assign rd_data_o = rd_q;

  // ==========================================================
  // Core domain: request detect and pin synchronisers
  logic req_s1_q, req_s2_q, req_seen_q, trip_s1_q, trip_q, trip_prev_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_seen_q <= 1'b0;
      trip_s1_q <= 1'b0;
      trip_q <= 1'b0;
      trip_prev_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_seen_q <= req_s2_q;
      trip_s1_q <= oc_trip_i;
      trip_q <= trip_s1_q;
      trip_prev_q <= trip_q;
    end
  end
  logic exec, wr, all_sel, bad;
  logic [1:0] pidx;
  logic signed [31:0] cur_val, tmp_val, cur_cap;
  assign exec = req_s2_q ^ req_seen_q;
  assign wr = exec && lreq_q.write && !bad;
  assign all_sel = phase_sel_i == PHASE_ALL;
  assign pidx = (32'(phase_sel_i) < NUM_PHASES) ? phase_sel_i[1:0] : 2'h0;
  assign cur_val = lin_val(lreq_q.data, CUR_FRAC);
  assign tmp_val = lin_val(lreq_q.data, TEMP_FRAC);
  assign cur_cap = all_sel ? CUR_MAX * NUM_PHASES : CUR_MAX;

  // Size and range checks on each write
  always_comb begin
    bad = 1'b0;
    case (lreq_q.cmd)
      CMD_OC_REACTION: bad = lreq_q.write && lreq_q.word;
      CMD_OC_WARN: bad = lreq_q.write && (!lreq_q.word ||
        cur_val < 0 || cur_val > cur_cap);
      CMD_OT_FAULT: bad = lreq_q.write && (!lreq_q.word ||
        tmp_val < 0 || tmp_val > OT_DISABLE);
      default: bad = 1'b1;
    endcase
  end

  // ==========================================================
  // Command registers
  reaction_t resp_q;
  logic [NUM_PHASES-1:0][9:0] warn_q;
  signed_linear_word_format_t ot_word_q;
  logic signed [31:0] ot_lim, ot_deg;
  assign ot_lim = lin_val(ot_word_q, TEMP_FRAC);
  assign ot_deg = (ot_lim + TEMP_ONE / 2) >>> TEMP_FRAC;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_q <= RESP_DEFAULT;
    end else if (wr && lreq_q.cmd == CMD_OC_REACTION) begin
      resp_q[7:3] <= lreq_q.data[7:3];
    end
  end
  // Phase writes, broadcast split and restore rounding
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      warn_q <= {NUM_PHASES{WARN_DEFAULT}};
    end else begin
      for (int p = 0; p < NUM_PHASES; p++) begin
        if (nvm_restore_i) begin
          warn_q[p] <= (warn_q[p] + 10'h001) & 10'h3FE;
        end else if (wr && lreq_q.cmd == CMD_OC_WARN) begin
          if (all_sel) begin
            warn_q[p] <= 10'(cur_val / NUM_PHASES);
          end else if (p == int'(pidx)) begin
            warn_q[p] <= 10'(cur_val);
          end
        end
      end
    end
  end
  // Restore keeps the disable code, else whole degrees in range
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_word_q <= {EXP_UNIT, OT_DEFAULT_DEG};
    end else if (nvm_restore_i && ot_lim != OT_DISABLE) begin
      ot_word_q.exponent <= EXP_UNIT;
      ot_word_q.mantissa <= (ot_deg < 0) ? 11'h000 :
        (ot_deg > OT_NVM_MAX) ? 11'(OT_NVM_MAX) : 11'(ot_deg);
    end else if (wr && lreq_q.cmd == CMD_OT_FAULT) begin
      ot_word_q <= lreq_q.data;
    end
  end
  // Read data and ack; delay bits always read the fixed default
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_word_q <= 16'h0000;
      ack_tgl_q <= 1'b0;
    end else if (exec) begin
      ack_tgl_q <= ~ack_tgl_q;
      case (lreq_q.cmd)
        CMD_OC_REACTION: rd_word_q <= {8'h00, resp_q[7:3],
          RESP_DEFAULT[2:0]};
        CMD_OC_WARN: rd_word_q <= all_sel ?
          {EXP_HALF, 11'((32'(warn_q[0]) * NUM_PHASES) >> 2)} :
          {EXP_EIGHTH, 1'b0, warn_q[pidx]};
        CMD_OT_FAULT: rd_word_q <= ot_word_q;
        default: rd_word_q <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Per-phase warning compare
  logic [NUM_PHASES-1:0][10:0] applied;
  logic [NUM_PHASES-1:0] pw_q;
  for (genvar i = 0; i < NUM_PHASES; i++) begin : g_phase
    logic [10:0] up;
    // Round up to the analog step, then floor at the minimum
    assign up = 11'((32'(warn_q[i]) + CUR_HW_STEP - 1) /
      CUR_HW_STEP * CUR_HW_STEP);
    assign applied[i] = (up < 11'(CUR_HW_MIN)) ?
      11'(CUR_HW_MIN) : up;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pw_q[i] <= 1'b0;
      end else begin
        pw_q[i] <= iout_meas_i[i] > applied[i];
      end
    end
  end
  assign phase_warn_o = pw_q;

  // ==========================================================
  // Overcurrent reaction and restart sequencing
  oc_state_t st_q, st_d;
  logic [31:0] cnt_q;
  logic [2:0] tries_q;
  logic pwr_q, trip_rise;
  assign trip_rise = trip_q && !trip_prev_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      OC_RUN: if (trip_q) begin
        if (resp_q.overcurrent_reaction_code == RC_NOW) begin
          st_d = OC_OFF;
        end else if (resp_q.overcurrent_reaction_code == RC_DELAYED) begin
          st_d = OC_DELAY;
        end
      end
      OC_DELAY: if (!trip_q) begin
        st_d = OC_RUN;
      end else if (cnt_q == 32'(SHUTDOWN_DELAY_CYC - 1)) begin
        st_d = OC_OFF;
      end
      OC_OFF: st_d = (resp_q.overcurrent_restart_count == RETRY_NONE) ?
        OC_LATCHED : OC_WAIT;
      OC_WAIT: if (cnt_q == 32'(RESTART_WAIT - 1)) begin
        st_d = OC_RESTART;
      end
      OC_RESTART: if (startup_ok_i) begin
        st_d = OC_RUN;
      end else if (trip_q) begin
        st_d = (resp_q.overcurrent_restart_count != RETRY_FOREVER &&
          tries_q >= resp_q.overcurrent_restart_count) ?
          OC_LATCHED : OC_WAIT;
      end
      OC_LATCHED: st_d = OC_LATCHED;
      default: st_d = OC_RUN;
    endcase
    if (!commanded_on_i) begin
      st_d = OC_RUN;
    end
  end
  // Counter restarts on every state change
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= OC_RUN;
      cnt_q <= 32'h0000_0000;
      tries_q <= 3'h0;
      pwr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
      if (st_d == OC_RUN) begin
        tries_q <= 3'h0;
      end else if (st_q == OC_WAIT && st_d == OC_RESTART &&
          tries_q != 3'h7) begin
        tries_q <= tries_q + 3'h1; // Saturates, never wraps
      end
      pwr_q <= commanded_on_i && (st_d == OC_RUN ||
        st_d == OC_DELAY || st_d == OC_RESTART);
    end
  end
  assign power_enable_o = pwr_q;

  // ==========================================================
  // Overtemperature fault with hysteresis
  logic ot_q, ot_dis;
  logic signed [31:0] ot_rel;
  assign ot_dis = ot_lim == OT_DISABLE;
  assign ot_rel = (32'(ot_warn_limit_i) > ot_lim) ?
    ot_lim - OT_HYST : 32'(ot_warn_limit_i);
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_q <= 1'b0;
    end else if (ot_dis) begin
      ot_q <= 1'b0;
    end else if (32'(temp_meas_i) > ot_lim) begin
      ot_q <= 1'b1;
    end else if (32'(temp_meas_i) < ot_rel) begin
      ot_q <= 1'b0;
    end
  end
  assign ot_fault_o = ot_q;

  // ==========================================================
  // Sticky status; a set in the clearing cycle wins
  status_t st_flags_q;
  logic warn_rise, cml_set, alert_n_q;
  logic [NUM_PHASES-1:0] pw_prev_q;
  assign warn_rise = |(pw_q & ~pw_prev_q);
  assign cml_set = exec && bad;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_flags_q <= '0;
      pw_prev_q <= '0;
      alert_n_q <= 1'b1;
    end else begin
      pw_prev_q <= pw_q;
      st_flags_q.byte_oc <= trip_rise ||
        (st_flags_q.byte_oc && !clear_faults_i);
      st_flags_q.iout_ocf <= trip_rise ||
        (st_flags_q.iout_ocf && !clear_faults_i);
      st_flags_q.word_iout <= trip_rise || warn_rise ||
        (st_flags_q.word_iout && !clear_faults_i);
      st_flags_q.byte_nota <= warn_rise || cml_set ||
        (st_flags_q.byte_nota && !clear_faults_i);
      st_flags_q.iout_ocw <= warn_rise ||
        (st_flags_q.iout_ocw && !clear_faults_i);
      st_flags_q.cml_data <= cml_set ||
        (st_flags_q.cml_data && !clear_faults_i);
      alert_n_q <= !(|st_flags_q); // Inverted before the flop, pin is clean
    end
  end
  assign status_o = st_flags_q;
  assign alert_n_o = alert_n_q;

  // ==========================================================
  // Checks
  oc_status_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    trip_rise |=> st_flags_q.iout_ocf ##1 !alert_n_o)
    else $error("overcurrent status not raised");
  ignore_code_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    st_q == OC_RUN && commanded_on_i &&
    !resp_q.overcurrent_reaction_code[1] |=> st_q == OC_RUN)
    else $error("ignore code left run state");
  immediate_off_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    st_q == OC_RUN && trip_q && commanded_on_i &&
    resp_q.overcurrent_reaction_code == RC_NOW |=> !power_enable_o)
    else $error("immediate shutdown missed");
  latch_off_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    st_q == OC_OFF && commanded_on_i &&
    resp_q.overcurrent_restart_count == RETRY_NONE
    |=> st_q == OC_LATCHED && !power_enable_o)
    else $error("zero count did not latch");
  retry_limit_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    st_q == OC_RESTART && trip_q && !startup_ok_i && commanded_on_i &&
    resp_q.overcurrent_restart_count != RETRY_FOREVER &&
    tries_q >= resp_q.overcurrent_restart_count |=> st_q == OC_LATCHED)
    else $error("retry limit not honoured");
  retry_forever_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    st_q == OC_RESTART && trip_q && !startup_ok_i && commanded_on_i &&
    resp_q.overcurrent_restart_count == RETRY_FOREVER |=> st_q == OC_WAIT)
    else $error("endless retry stopped");
  invalid_data_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    cml_set |=> st_flags_q.cml_data ##1 !alert_n_o)
    else $error("invalid data not flagged");
  phase_step_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    applied[0] % CUR_HW_STEP == 0 && applied[0] >= CUR_HW_MIN &&
    applied[0] <= CUR_MAX)
    else $error("applied limit off grid");
  phase_warn_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    iout_meas_i[0] > applied[0] |=> phase_warn_o[0])
    else $error("phase warning missed");
  ot_disable_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    ot_dis |=> !ot_fault_o)
    else $error("disabled limit raised fault");
endmodule : oc_ot_config

// ---- hdl/oc_ot_pkg.sv ----
// Package: command codes, field layouts, scaling and timing constants
package oc_ot_pkg;
  // ==========================================================
  // Command codes and phase selector
  localparam logic [7:0] CMD_OC_REACTION = 8'h47;
  localparam logic [7:0] CMD_OC_WARN = 8'h4A;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [1:0] overcurrent_reaction_code;
    logic [2:0] overcurrent_restart_count;
    logic [2:0] overcurrent_shutdown_delay;
  } reaction_t;
  typedef struct packed {
    logic [4:0] exponent;
    logic [10:0] mantissa;
  } signed_linear_word_format_t;
  typedef struct packed {
    logic write;
    logic word;
    logic [7:0] cmd;
    logic [15:0] data;
  } txn_t;
  typedef struct packed {
    logic byte_oc;
    logic byte_nota;
    logic word_iout;
    logic iout_ocf;
    logic iout_ocw;
    logic cml_data;
  } status_t;
  localparam logic [1:0] RC_DELAYED = 2'h2;
  localparam logic [1:0] RC_NOW = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // ==========================================================
  // Scaling: current in 1/8 A, temperature in 1/16 degC
  localparam int CUR_FRAC = 3;
  localparam int CUR_HW_STEP = 16;
  localparam int CUR_HW_MIN = 64;
  localparam int CUR_MAX = 496;
  localparam int TEMP_FRAC = 4;
  localparam int TEMP_ONE = 16;
  localparam int OT_DISABLE = 4080;
  localparam int OT_NVM_MAX = 160;
  localparam int OT_HYST = 320;
  localparam logic [4:0] EXP_EIGHTH = 5'h1D;
  localparam logic [4:0] EXP_HALF = 5'h1F;
  localparam logic [4:0] EXP_UNIT = 5'h00;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHUTDOWN_DELAY_NS = 70;
  localparam int SHUTDOWN_DELAY_CYC =
    (SHUTDOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_WAIT_NS = 2000000;
  localparam int RESTART_WAIT_CYC = RESTART_WAIT_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    OC_RUN = 3'b000,
    OC_DELAY = 3'b001,
    OC_OFF = 3'b010,
    OC_WAIT = 3'b011,
    OC_RESTART = 3'b100,
    OC_LATCHED = 3'b101
  } oc_state_t;
endpackage : oc_ot_pkg
